/* File: cpumc_mode_ctrl.sv */
`timescale 1ns/100ps
// Functional notes
// [R1] reset puts the core in real-address mode with 16-bit environment; code clears env_q at reset, 16-bit only from the first clock after release
// [R2] system-management entry from the pin or from the interrupt controller message
// [R3] entry saves the interrupted context, then selects the separate address space
// [R4] return restores the saved context and previous mode exactly
// [R5] virtual-8086 is a per-task flag inside protected mode only
// [R6] long sub-mode chosen from the current code segment's 64-bit attribute
// [R7] compatibility keeps 4 GByte linear space, 16 or 32-bit sizes
// [R8] compatibility forbids virtual-8086 and hardware task switch, keeps privilege levels
// [R9] 64-bit sub-mode has sixteen 64-bit general and sixteen SIMD registers
// [R10] 64-bit sub-mode defaults to 64-bit address, 32-bit operand size
// [R11] extension prefix with size override changes operand size per instruction
// [R12] extension prefix opens added registers and 64-bit operands in 64-bit mode
// [R13] outside long mode linear space 4 GBytes, physical 64 GBytes; code gives real and management modes a 20-bit linear space
// [R14] 32-bit general registers reachable as 8 or 16-bit in all modes
// [R15] compatibility allows physical memory above 4 GByte through address extension
// [R16] mode derives from five mode-control registers; code decodes only register 0 and the long-mode, segment and task inputs
// [R17] 64-bit sub-mode stack pointer fixed at 64 bits, no override
// [R18] mode state changes only on reset, management entry/return, or register write
module cpumc_mode_ctrl
	import cpumc_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// platform interrupt sources
	input wire logic sys_mgmt_irq_pin_n,
	input wire logic advanced_irq_controller_smi,
	input wire logic sys_mgmt_return,
	// software access to the mode-control registers
	input wire cpumc_wr_t ctrl_wr,
	input wire logic long_mode_active,
	input wire logic cs_long_attr,
	input wire logic cs_default_32,
	input wire logic task_v86_flag,
	// per-instruction prefixes
	input wire cpumc_prefix_t prefix,
	// results
	output cpumc_mode_t mode_q,
	output logic sys_mgmt_mode_q,
	output logic sys_mgmt_enter_q,
	output cpumc_env_t env_q,
	output logic [7:0] insn_oper_size_q,
	output logic [7:0] insn_addr_size_q,
	output logic insn_ext_regs_q,
	output logic [31:0] mode_control_reg_0_q,
	output logic [31:0] mode_control_reg_4_q
);
	logic pin_s1_q, pin_s1_d, pin_s2_q, pin_s2_d;
	logic [31:0] ctrl_q [NUM_CTRL_REGS];
	logic [31:0] ctrl_d [NUM_CTRL_REGS];
	logic [31:0] saved_cr0_q, saved_cr0_d, saved_cr4_q, saved_cr4_d;
	cpumc_mode_t saved_mode_q, saved_mode_d;
	logic sys_mgmt_d, enter_d;
	cpumc_mode_t mode_d, base_mode;
	cpumc_env_t env_d;
	logic [7:0] op_d, ad_d;
	logic ext_d;
	logic sys_mgmt_interrupt;
	logic prot_en_next;

	// pin is asynchronous: two flops before use
	always_comb
	begin
		pin_s1_d = ~sys_mgmt_irq_pin_n;
		pin_s2_d = pin_s1_q;
	end

	assign sys_mgmt_interrupt = pin_s2_q | advanced_irq_controller_smi; // [R2]

	// mode from control registers and code segment
	always_comb
	begin
		// a write this cycle decides the new mode, so use the value being written, not the stale one
		prot_en_next = ctrl_q[0][CR0_PROT_EN_BIT];
		if (ctrl_wr.valid && ctrl_wr.index == 3'h0)
			prot_en_next = ctrl_wr.data[CR0_PROT_EN_BIT];
		if (!prot_en_next)
			base_mode = MODE_REAL;
		else if (long_mode_active && cs_long_attr)
			base_mode = MODE_LONG64; // [R6]
		else if (long_mode_active)
			base_mode = MODE_COMPAT; // [R6]
		else if (task_v86_flag)
			base_mode = MODE_V86; // [R5]
		else
			base_mode = MODE_PROT; // [R16]
	end

	always_comb
	begin
		for (int i = 0; i < NUM_CTRL_REGS; i++)
			ctrl_d[i] = ctrl_q[i];
		saved_cr0_d = saved_cr0_q;
		saved_cr4_d = saved_cr4_q;
		saved_mode_d = saved_mode_q;
		sys_mgmt_d = sys_mgmt_mode_q;
		enter_d = 1'b0;
		mode_d = mode_q;
		if (!sys_mgmt_mode_q && sys_mgmt_interrupt)
		begin
			// save context before switching to the private space
			saved_cr0_d = ctrl_q[0]; // [R3]
			saved_cr4_d = ctrl_q[4]; // [R3]
			saved_mode_d = mode_q; // [R3]
			sys_mgmt_d = 1'b1;
			enter_d = 1'b1;
			mode_d = MODE_SMM; // [R18]
		end
		else if (sys_mgmt_mode_q && sys_mgmt_return)
		begin
			ctrl_d[0] = saved_cr0_q; // [R4]
			ctrl_d[4] = saved_cr4_q; // [R4]
			sys_mgmt_d = 1'b0;
			mode_d = saved_mode_q; // [R4]
		end
		else
		begin
			if (ctrl_wr.valid && ctrl_wr.index < 3'(NUM_CTRL_REGS))
				ctrl_d[ctrl_wr.index] = ctrl_wr.data;
			// segment and task inputs only change the mode alongside a register write; cs_default_32 sets the sizes every cycle in MODE_PROT and MODE_COMPAT
			if (!sys_mgmt_mode_q && ctrl_wr.valid)
				mode_d = base_mode; // [R18]
		end
	end

	// environment per mode
	always_comb
	begin
		env_d = '0;
		env_d.sub_reg_access = 1'b1; // [R14]
		env_d.gpr_count = GPR_COUNT_LEGACY;
		env_d.simd_count = GPR_COUNT_LEGACY;
		env_d.gpr_width = ADDR_WIDTH_32;
		env_d.lin_addr_bits = LIN_ADDR_BITS_LEGACY; // [R13]
		env_d.phys_addr_bits = PHYS_ADDR_BITS_LEGACY; // [R13]
		env_d.addr_size = cs_default_32 ? ADDR_WIDTH_32 : ADDR_WIDTH_16;
		env_d.oper_size = env_d.addr_size;
		env_d.stack_size = env_d.addr_size;
		env_d.hw_task_sw_ok = 1'b1;
		env_d.pae_ok = ctrl_d[4][CR4_PAE_BIT];
		case (mode_d)
			MODE_REAL, MODE_SMM:
			begin
				env_d.addr_size = ADDR_WIDTH_16; // [R1]
				env_d.oper_size = ADDR_WIDTH_16; // [R1]
				env_d.stack_size = ADDR_WIDTH_16;
				env_d.lin_addr_bits = LIN_ADDR_BITS_REAL;
				env_d.hw_task_sw_ok = 1'b0;
			end
			MODE_PROT:
				env_d.v86_ok = 1'b1; // [R5]
			MODE_V86:
			begin
				env_d.v86_ok = 1'b1;
				env_d.addr_size = ADDR_WIDTH_16;
				env_d.oper_size = ADDR_WIDTH_16;
			end
			MODE_COMPAT:
			begin
				env_d.v86_ok = 1'b0; // [R8]
				env_d.hw_task_sw_ok = 1'b0; // [R8]
				env_d.lin_addr_bits = LIN_ADDR_BITS_LEGACY; // [R7]
				env_d.pae_ok = 1'b1; // [R15]
			end
			MODE_LONG64:
			begin
				env_d.gpr_count = GPR_COUNT_LONG; // [R9]
				env_d.simd_count = GPR_COUNT_LONG; // [R9]
				env_d.gpr_width = ADDR_WIDTH_64; // [R9]
				env_d.addr_size = ADDR_WIDTH_64; // [R10]
				env_d.oper_size = ADDR_WIDTH_32; // [R10]
				env_d.stack_size = ADDR_WIDTH_64; // [R17]
				env_d.lin_addr_bits = LIN_ADDR_BITS_LONG;
				env_d.ext_regs_ok = 1'b1; // [R12]
				env_d.hw_task_sw_ok = 1'b0;
				env_d.pae_ok = 1'b1;
			end
			default:
				env_d.v86_ok = 1'b0;
		endcase
	end

	// per-instruction effective sizes
	always_comb
	begin
		op_d = env_q.oper_size;
		ad_d = env_q.addr_size;
		ext_d = 1'b0;
		if (prefix.valid)
		begin
			if (mode_q == MODE_LONG64)
			begin
				ext_d = prefix.reg_ext; // [R12]
				if (prefix.reg_ext && prefix.reg_ext_w)
					op_d = ADDR_WIDTH_64; // [R11]
				else if (prefix.opsize_ovr)
					op_d = ADDR_WIDTH_16; // [R11]
				if (prefix.addrsize_ovr)
					ad_d = ADDR_WIDTH_32;
			end
			else
			begin
				// only 16 and 32 exist outside 64-bit sub-mode
				if (prefix.opsize_ovr)
					op_d = (env_q.oper_size == ADDR_WIDTH_32) ? ADDR_WIDTH_16 : ADDR_WIDTH_32; // [R7]
				if (prefix.addrsize_ovr)
					ad_d = (env_q.addr_size == ADDR_WIDTH_32) ? ADDR_WIDTH_16 : ADDR_WIDTH_32; // [R7]
			end
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			for (int i = 0; i < NUM_CTRL_REGS; i++)
				ctrl_q[i] <= CTRL_RESET_VAL;
			saved_cr0_q <= CTRL_RESET_VAL;
			saved_cr4_q <= CTRL_RESET_VAL;
			saved_mode_q <= MODE_REAL;
			sys_mgmt_mode_q <= 1'b0;
			sys_mgmt_enter_q <= 1'b0;
			mode_q <= MODE_REAL; // [R1]
			env_q <= '0;
			insn_oper_size_q <= ADDR_WIDTH_16;
			insn_addr_size_q <= ADDR_WIDTH_16;
			insn_ext_regs_q <= 1'b0;
			mode_control_reg_0_q <= CTRL_RESET_VAL;
			mode_control_reg_4_q <= CTRL_RESET_VAL;
		end
		else
		begin
			pin_s1_q <= pin_s1_d;
			pin_s2_q <= pin_s2_d;
			for (int i = 0; i < NUM_CTRL_REGS; i++)
				ctrl_q[i] <= ctrl_d[i];
			saved_cr0_q <= saved_cr0_d;
			saved_cr4_q <= saved_cr4_d;
			saved_mode_q <= saved_mode_d;
			sys_mgmt_mode_q <= sys_mgmt_d;
			sys_mgmt_enter_q <= enter_d;
			mode_q <= mode_d;
			env_q <= env_d;
			insn_oper_size_q <= op_d;
			insn_addr_size_q <= ad_d;
			insn_ext_regs_q <= ext_d;
			mode_control_reg_0_q <= ctrl_d[0];
			mode_control_reg_4_q <= ctrl_d[4];
		end
	end

	property p_entry;
		@(posedge clock) disable iff (!nrst)
		(!sys_mgmt_mode_q && sys_mgmt_interrupt) |=> (sys_mgmt_mode_q && mode_q == MODE_SMM && sys_mgmt_enter_q);
	endproperty
	a_entry: assert property (p_entry) else $error("management entry missed"); // [R2]

	property p_save;
		@(posedge clock) disable iff (!nrst)
		sys_mgmt_enter_q |-> (saved_mode_q == $past(mode_q) && saved_cr0_q == $past(mode_control_reg_0_q));
	endproperty
	a_save: assert property (p_save) else $error("context not saved on entry"); // [R3]

	property p_return;
		@(posedge clock) disable iff (!nrst)
		(sys_mgmt_mode_q && sys_mgmt_return && !sys_mgmt_enter_q) |=> (mode_q == $past(saved_mode_q) && !sys_mgmt_mode_q);
	endproperty
	a_return: assert property (p_return) else $error("previous mode not restored"); // [R4]

	property p_v86;
		@(posedge clock) disable iff (!nrst)
		(mode_q == MODE_V86) |-> mode_control_reg_0_q[CR0_PROT_EN_BIT];
	endproperty
	a_v86: assert property (p_v86) else $error("v86 outside protected mode"); // [R5]

	property p_compat;
		@(posedge clock) disable iff (!nrst)
		##1 ($past(mode_d) == MODE_COMPAT) |-> (!env_q.v86_ok && !env_q.hw_task_sw_ok && env_q.lin_addr_bits == 8'h20);
	endproperty
	a_compat: assert property (p_compat) else $error("compatibility limits broken"); // [R8]

	property p_long;
		@(posedge clock) disable iff (!nrst)
		##1 ($past(mode_d) == MODE_LONG64) |-> (env_q.gpr_count == 5'h10 && env_q.addr_size == 8'h40
			&& env_q.oper_size == 8'h20 && env_q.stack_size == 8'h40);
	endproperty
	a_long: assert property (p_long) else $error("64-bit environment wrong"); // [R10]

	property p_rexw;
		@(posedge clock) disable iff (!nrst)
		(prefix.valid && prefix.reg_ext && prefix.reg_ext_w && mode_q == MODE_LONG64) |=> insn_oper_size_q == 8'h40;
	endproperty
	a_rexw: assert property (p_rexw) else $error("extension prefix ignored"); // [R11]

	property p_stable;
		@(posedge clock) disable iff (!nrst)
		(!ctrl_wr.valid && !sys_mgmt_interrupt && !(sys_mgmt_mode_q && sys_mgmt_return)) |=> $stable(mode_q);
	endproperty
	a_stable: assert property (p_stable) else $error("mode changed without cause"); // [R18]

	property p_legacy;
		@(posedge clock) disable iff (!nrst)
		##1 ($past(mode_d) == MODE_PROT) |-> (env_q.lin_addr_bits == 8'h20 && env_q.phys_addr_bits == 8'h24);
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy address limits wrong"); // [R13]
endmodule

/* File: cpumc_pkg.sv */
package cpumc_pkg;
	typedef enum logic [2:0] {
		MODE_REAL,
		MODE_PROT,
		MODE_V86,
		MODE_COMPAT,
		MODE_LONG64,
		MODE_SMM
	} cpumc_mode_t;

	// mode-control register 0 field positions
	localparam int CR0_PROT_EN_BIT = 0;
	localparam int CR0_PAGING_BIT = 31;
	// mode-control register 4 field positions
	localparam int CR4_PAE_BIT = 5;
	localparam int NUM_CTRL_REGS = 5;
	localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;
	localparam logic [7:0] ADDR_WIDTH_16 = 8'h10;
	localparam logic [7:0] ADDR_WIDTH_32 = 8'h20;
	localparam logic [7:0] ADDR_WIDTH_64 = 8'h40;
	localparam logic [7:0] LIN_ADDR_BITS_LEGACY = 8'h20;
	localparam logic [7:0] LIN_ADDR_BITS_REAL = 8'h14;
	localparam logic [7:0] LIN_ADDR_BITS_LONG = 8'h40;
	localparam logic [7:0] PHYS_ADDR_BITS_LEGACY = 8'h24;
	localparam logic [4:0] GPR_COUNT_LEGACY = 5'h08;
	localparam logic [4:0] GPR_COUNT_LONG = 5'h10;

	typedef struct packed {
		logic [7:0] addr_size;
		logic [7:0] oper_size;
		logic [7:0] stack_size;
		logic [7:0] lin_addr_bits;
		logic [7:0] phys_addr_bits;
		logic [4:0] gpr_count;
		logic [4:0] simd_count;
		logic [7:0] gpr_width;
		logic sub_reg_access;
		logic ext_regs_ok;
		logic v86_ok;
		logic hw_task_sw_ok;
		logic pae_ok;
	} cpumc_env_t;

	typedef struct packed {
		logic valid;
		logic [2:0] index;
		logic [31:0] data;
	} cpumc_wr_t;

	typedef struct packed {
		logic valid;
		logic reg_ext;
		logic reg_ext_w;
		logic opsize_ovr;
		logic addrsize_ovr;
	} cpumc_prefix_t;
endpackage

/* File: cpumc_irq_src.sv */
`timescale 1ns/100ps
module cpumc_irq_src
(
	// clock
	input wire logic clock,
	// commands from the bench
	input wire logic pin_go,
	input wire logic ctl_go,
	// lines into the core
	output logic pin_n,
	output logic ctl_smi
);
	logic [2:0] hold_q;
	initial
	begin
		hold_q = 3'h0;
		pin_n = 1'b1;
		ctl_smi = 1'b0;
	end
	// pin held low for four edges so the two-flop synchroniser cannot miss it, pulled up when idle
	always @(posedge clock)
	begin
		hold_q <= pin_go ? 3'h4 : (hold_q != 3'h0 ? hold_q - 3'h1 : 3'h0);
		pin_n <= !(pin_go || hold_q > 3'h1);
		ctl_smi <= ctl_go; // one-cycle controller message
	end
endmodule

/* File: cpumc_mode_ctrl_tb.sv */
`timescale 1ns/100ps
module cpumc_mode_ctrl_tb
	import cpumc_pkg::*;
;
	// lcv packs long-mode, code-segment and task flags
	typedef struct packed {
		logic [2:0] idx;
		logic [31:0] data;
		logic [2:0] lcv;
		cpumc_mode_t mode;
		logic [4:0] gpr;
		logic [7:0] lin;
	} cpumc_row_t;
	cpumc_row_t rows [7] = '{
		'{3'h0, 32'h0000_0001, 3'h0, MODE_PROT, 5'h08, 8'h20},
		'{3'h0, 32'h0000_0001, 3'h1, MODE_V86, 5'h08, 8'h20},
		'{3'h4, 32'h0000_0020, 3'h0, MODE_PROT, 5'h08, 8'h20},
		'{3'h0, 32'h8000_0001, 3'h4, MODE_COMPAT, 5'h08, 8'h20},
		'{3'h0, 32'h8000_0001, 3'h5, MODE_COMPAT, 5'h08, 8'h20},
		'{3'h0, 32'h8000_0001, 3'h6, MODE_LONG64, 5'h10, 8'h40},
		'{3'h0, 32'h0000_0000, 3'h1, MODE_REAL, 5'h08, 8'h14}
	};
	logic clock, nrst, pin_go, ctl_go, pin_n, ctl_smi, ret, lma, csl, cs32, v86;
	cpumc_wr_t wr;
	cpumc_prefix_t pfx;
	cpumc_mode_t mode_q;
	logic smm_q, enter_q, ext_q;
	cpumc_env_t env_q;
	logic [7:0] osz_q, asz_q;
	logic [31:0] r0_q, r4_q;
	int mismatches, n_checks, cycles;

	cpumc_irq_src u_src (.clock(clock), .pin_go(pin_go), .ctl_go(ctl_go), .pin_n(pin_n), .ctl_smi(ctl_smi));
	cpumc_mode_ctrl u_dut (.clock(clock), .nrst(nrst), .sys_mgmt_irq_pin_n(pin_n),
		.advanced_irq_controller_smi(ctl_smi), .sys_mgmt_return(ret), .ctrl_wr(wr),
		.long_mode_active(lma), .cs_long_attr(csl), .cs_default_32(cs32), .task_v86_flag(v86),
		.prefix(pfx), .mode_q(mode_q), .sys_mgmt_mode_q(smm_q), .sys_mgmt_enter_q(enter_q),
		.env_q(env_q), .insn_oper_size_q(osz_q), .insn_addr_size_q(asz_q), .insn_ext_regs_q(ext_q),
		.mode_control_reg_0_q(r0_q), .mode_control_reg_4_q(r4_q));

	task automatic summarize;
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_m(input cpumc_mode_t got, input cpumc_mode_t exp);
		chk({29'h0, got}, {29'h0, exp});
	endtask

	task automatic wr_op(input logic [2:0] i, input logic [31:0] d, input logic [2:0] f);
		@(posedge clock);
		wr <= '{1'b1, i, d};
		{lma, csl, v86} <= f;
		@(posedge clock);
		wr.valid <= 1'b0;
		#1;
	endtask

	task automatic pf(input logic [3:0] p, input logic [7:0] eo, input logic [7:0] ea, input logic ex);
		@(posedge clock);
		pfx <= {1'b1, p};
		@(posedge clock);
		pfx.valid <= 1'b0;
		#1;
		chk(osz_q, eo);
		chk(asz_q, ea);
		chk(ext_q, ex);
	endtask

	// entry, a register write while inside that leaves the mode at MODE_SMM, then return to the saved long mode
	task automatic smi_ret(input logic by_pin);
		int k;
		k = 0;
		@(posedge clock);
		if (by_pin)
			pin_go <= 1'b1;
		else
			ctl_go <= 1'b1;
		@(posedge clock);
		pin_go <= 1'b0;
		ctl_go <= 1'b0;
		while (smm_q !== 1'b1 && k < 10)
		begin
			@(posedge clock);
			#1;
			k++;
		end
		chk_m(mode_q, MODE_SMM);
		chk(enter_q, 1'b1);
		wr_op(3'h0, 32'h0000_0000, 3'h0);
		chk_m(mode_q, MODE_SMM);
		chk(enter_q, 1'b0);
		@(posedge clock);
		ret <= 1'b1;
		@(posedge clock);
		ret <= 1'b0;
		#1;
		chk_m(mode_q, MODE_LONG64);
		chk(r0_q, 32'h8000_0001);
	endtask

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			summarize();
		end
	end

	initial
	begin
		{nrst, pin_go, ctl_go, ret, lma, csl, v86} = 7'h0;
		cs32 = 1'b1;
		wr = '0;
		pfx = '0;
		repeat (4) @(posedge clock);
		chk_m(mode_q, MODE_REAL);
		chk(osz_q, 8'h10);
		nrst <= 1'b1;
		@(posedge clock);
		#1;
		chk(env_q.addr_size, 8'h10);
		chk(env_q.sub_reg_access, 1'b1);
		for (int i = 0; i < 7; i++)
		begin
			wr_op(rows[i].idx, rows[i].data, rows[i].lcv);
			chk_m(mode_q, rows[i].mode);
			chk(env_q.gpr_count, rows[i].gpr);
			chk(env_q.lin_addr_bits, rows[i].lin);
		end
		chk(r4_q, 32'h0000_0020);
		chk(env_q.phys_addr_bits, 8'h24);
		wr_op(3'h0, 32'h8000_0001, 3'h4);
		chk(env_q.pae_ok, 1'b1);
		chk({env_q.v86_ok, env_q.hw_task_sw_ok}, 2'h0);
		wr_op(3'h0, 32'h8000_0001, 3'h6);
		chk({env_q.addr_size, env_q.oper_size}, 16'h4020);
		chk(env_q.stack_size, 8'h40);
		chk({env_q.gpr_width, env_q.simd_count}, 13'h0810);
		chk(env_q.ext_regs_ok, 1'b1);
		chk(env_q.sub_reg_access, 1'b1);
		pf(4'h0, 8'h20, 8'h40, 1'b0);
		pf(4'hE, 8'h40, 8'h40, 1'b1);
		pf(4'h2, 8'h10, 8'h40, 1'b0);
		pf(4'h1, 8'h20, 8'h20, 1'b0);
		@(posedge clock);
		{lma, csl, v86} <= 3'h1;
		// a return outside management mode must be ignored
		ret <= 1'b1;
		@(posedge clock);
		ret <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk_m(mode_q, MODE_LONG64);
		smi_ret(1'b0);
		smi_ret(1'b1);
		// compatibility with a 16-bit code segment, then size overrides outside 64-bit
		@(posedge clock);
		cs32 <= 1'b0;
		wr_op(3'h0, 32'h8000_0001, 3'h4);
		chk(env_q.addr_size, 8'h10);
		pf(4'h2, 8'h20, 8'h10, 1'b0);
		pf(4'h1, 8'h10, 8'h20, 1'b0);
		@(posedge clock);
		nrst <= 1'b0;
		@(posedge clock);
		#1;
		chk_m(mode_q, MODE_REAL);
		chk(smm_q, 1'b0);
		nrst <= 1'b1;
		@(posedge clock);
		summarize();
	end
endmodule
